/* test_tlp_error_checker.sv */
// Self-checking bench of the received-packet error checker.
// Assumes the link partner model beside it; expected packets are kept in a queue.
`timescale 1ns/1ps
module test_tlp_error_checker;
  logic clk_sys, rst_n, rx_valid, rx_ready, rx_digest, fc_update, app_valid, app_ready;
  logic req_valid, link_up, silent, starve, hold, err_msg_fatal, err_msg_nonfatal, en_fatal, en_nonfatal;
  logic [11:0] rx_words;
  logic [2:0] app_err_report;
  logic [5:0] err_status, err_clear;
  logic [7:0] rnd;
  tlp_chk_pkg::tlp_hdr_t rx_hdr, app_hdr, h;
  tlp_chk_pkg::credit_t rx_credit [3];
  tlp_chk_pkg::req_info_t req_info;
  tlp_chk_pkg::tlp_hdr_t exp_q[$];
  int fails, comparisons, n_fatal, n_nonfatal;

  tlp_error_checker #(.FC_LIMIT(20)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .cfg_id(16'h0100),
    .cfg_tag_limit(8'h10), .cfg_mps(3'h0), .link_up(link_up), .report_en_fatal(en_fatal),
    .report_en_nonfatal(en_nonfatal), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_hdr(rx_hdr),
    .rx_words(rx_words), .rx_digest(rx_digest), .rx_credit(rx_credit), .fc_update(fc_update),
    .app_valid(app_valid), .app_ready(app_ready), .app_hdr(app_hdr), .req_valid(req_valid),
    .req_info(req_info), .app_err_report(app_err_report), .err_status(err_status),
    .err_clear(err_clear), .err_msg_fatal(err_msg_fatal), .err_msg_nonfatal(err_msg_nonfatal));
  tlp_link_partner partner_u (.clk_sys(clk_sys), .rst_n(rst_n), .silent(silent), .starve(starve),
    .fc_update(fc_update), .rx_credit(rx_credit));

  // ****************
  // Helpers
  // ****************
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Header with our own requester identity and legal byte enables for its length.
  function automatic tlp_chk_pkg::tlp_hdr_t mk(input logic [2:0] f, input logic [4:0] t, input logic [9:0] l);
    tlp_chk_pkg::tlp_hdr_t r;
    r = '0;
    r.fmt = f;
    r.ftype = t;
    r.len = l;
    r.first_be = 4'hF;
    r.last_be = (l > 10'h001) ? 4'hF : 4'h0;
    r.req_id = 16'h0100;
    return r;
  endfunction

  task automatic check(input logic [79:0] got, input logic [79:0] want);
    comparisons++;
    if (got !== want) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, want);
    end
  endtask

  // Offers one packet and holds it until the edge that takes it.
  task automatic offer(input tlp_chk_pkg::tlp_hdr_t p, input logic [11:0] w, input logic d, input bit good);
    int n;
    n = 0;
    rx_hdr = p;
    rx_words = w;
    rx_digest = d;
    rx_valid = 1'b1;
    while (rx_ready !== 1'b1 && n < 50) begin
      @(posedge clk_sys);
      #2;
      n++;
    end
    @(posedge clk_sys);
    #2;
    if (good) exp_q.push_back(p);
  endtask

  // Status is sticky, so looking one edge late still sees the bit; then clear all.
  task automatic status(input logic [5:0] e);
    @(posedge clk_sys);
    #2;
    check(err_status, e);
    err_clear = 6'h3F;
    @(posedge clk_sys);
    #2;
    err_clear = 6'h00;
  endtask

  task automatic pkt(input tlp_chk_pkg::tlp_hdr_t p, input logic [11:0] w, input logic d, input logic [5:0] e);
    offer(p, w, d, e == 6'h00);
    rx_valid = 1'b0;
    status(e);
  endtask

  task automatic req(input logic [7:0] t, input logic c, input logic i);
    req_info = '{tag: t, is_cfg: c, is_io: i};
    req_valid = 1'b1;
    @(posedge clk_sys);
    #2;
    req_valid = 1'b0;
  endtask

  task automatic report(input logic [2:0] v, input logic [5:0] e);
    app_err_report = v;
    @(posedge clk_sys);
    #2;
    app_err_report = 3'h0;
    status(e);
  endtask

  task automatic results();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ****************
  // Clock, stall pattern, delivery model
  // ****************
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // The application stalls at random, so delivery is seen under back-pressure.
  always begin
    @(posedge clk_sys);
    #2;
    rnd = lfsr(rnd);
    app_ready = !hold && rnd[0];
  end

  // Every delivered packet must be the next one the model expects; nothing else may appear.
  always @(posedge clk_sys) begin
    if (rst_n && app_valid === 1'b1 && app_ready === 1'b1) begin
      if (exp_q.size() == 0) check(1, 0);
      else check(app_hdr, exp_q.pop_front());
    end
    n_fatal += err_msg_fatal === 1'b1;
    n_nonfatal += err_msg_nonfatal === 1'b1;
  end

  initial begin
    #(4000 * 25);
    fails++;
    results();
  end

  // ****************
  // Scenarios
  // ****************
  initial begin
    {rst_n, rx_valid, rx_digest, link_up, silent, starve, hold, app_ready, req_valid} = '0;
    {fails, comparisons, n_fatal, n_nonfatal} = '0;
    rx_hdr = '0;
    rx_words = 12'h000;
    req_info = '0;
    app_err_report = 3'h0;
    err_clear = 6'h00;
    rnd = 8'h14;
    {en_fatal, en_nonfatal} = 2'h3;
    repeat (2) @(posedge clk_sys);
    #2;
    rst_n = 1'b1;
    check({err_status, rx_ready, app_valid}, 8'h02);
    link_up = 1'b1;
    h = mk(3'h2, tlp_chk_pkg::T_MEM, 10'h001);
    h.addr = {2'h0, rnd, 2'h0};
    pkt(h, 12'h004, 1'b0, 6'h00);
    pkt(h, 12'h004, 1'b1, 6'h20);
    pkt(mk(3'h2, tlp_chk_pkg::T_MEM, 10'h021), 12'h024, 1'b0, 6'h20);
    pkt(mk(3'h2, tlp_chk_pkg::T_MEM, 10'h020), 12'h023, 1'b0, 6'h00);
    h.last_be = 4'hF;
    pkt(h, 12'h004, 1'b0, 6'h20);
    pkt(mk(3'h2, tlp_chk_pkg::T_MEM, 10'h001), 12'h005, 1'b0, 6'h20);
    pkt(mk(3'h0, 5'h03, 10'h001), 12'h003, 1'b0, 6'h20);
    h = mk(3'h2, tlp_chk_pkg::T_MEM, 10'h002);
    h.addr = 12'hFFC;
    pkt(h, 12'h005, 1'b0, 6'h20);
    h = mk(3'h1, 5'h10, 10'h000);
    h.msg_code = 8'h20;
    h.tc = 3'h1;
    pkt(h, 12'h004, 1'b0, 6'h20);
    h.tc = tlp_chk_pkg::TC_DEFAULT;
    pkt(h, 12'h004, 1'b0, 6'h00);
    starve = 1'b1;
    pkt(mk(3'h2, tlp_chk_pkg::T_MEM, 10'h001), 12'h004, 1'b0, 6'h08);
    starve = 1'b0;
    req(8'h05, 1'b0, 1'b0);
    h = mk(3'h2, tlp_chk_pkg::T_CPL, 10'h001);
    h.tag = 8'h05;
    pkt(h, 12'h004, 1'b0, 6'h00);
    pkt(h, 12'h004, 1'b0, 6'h04);
    req(8'h05, 1'b0, 1'b0);
    h.req_id = 16'h0200;
    pkt(h, 12'h004, 1'b0, 6'h04);
    h.req_id = 16'h0100;
    h.tag = 8'h10;
    pkt(h, 12'h004, 1'b0, 6'h04);
    req(8'h06, 1'b0, 1'b1);
    h = mk(3'h2, tlp_chk_pkg::T_CPL, 10'h002);
    h.tag = 8'h06;
    pkt(h, 12'h005, 1'b0, 6'h04);
    req(8'h07, 1'b1, 1'b0);
    h = mk(3'h0, tlp_chk_pkg::T_CPL, 10'h001);
    h.cpl_status = tlp_chk_pkg::CPL_CRS;
    h.tag = 8'h05;
    pkt(h, 12'h003, 1'b0, 6'h04);
    h.tag = 8'h07;
    pkt(h, 12'h003, 1'b0, 6'h00);
    h = mk(3'h2, tlp_chk_pkg::T_CPL, 10'h001);
    h.tag = 8'h05;
    pkt(h, 12'h004, 1'b0, 6'h00);
    report(3'h1, 6'h01);
    // A disabled severity still logs its status bit but sends no message.
    en_nonfatal = 1'b0;
    report(3'h4, 6'h02);
    en_nonfatal = 1'b1;
    // The buffer must be empty before the stall, or the two offers below would not both fit.
    while (app_valid !== 1'b0) begin
      @(posedge clk_sys);
      #2;
    end
    hold = 1'b1;
    repeat (4) @(posedge clk_sys);
    #2;
    h = mk(3'h2, tlp_chk_pkg::T_MEM, 10'h001);
    offer(h, 12'h004, 1'b0, 1'b1);
    h.addr = 12'h010;
    offer(h, 12'h004, 1'b0, 1'b1);
    check({rx_ready, app_valid}, 2'h1);
    hold = 1'b0;
    h.addr = 12'h020;
    offer(h, 12'h004, 1'b0, 1'b1);
    rx_valid = 1'b0;
    silent = 1'b1;
    repeat (10) @(posedge clk_sys);
    #2;
    check(err_status[4], 1'b0);
    repeat (20) @(posedge clk_sys);
    #2;
    check(err_status[4], 1'b1);
    silent = 1'b0;
    status(6'h10);
    repeat (20) @(posedge clk_sys);
    #2;
    // Seven malformed, one overrun and one watchdog event are fatal; one abort report was muted.
    check(n_fatal, 80'd9);
    check(n_nonfatal, 80'd6);
    check(exp_q.size(), 80'd0);
    results();
  end
endmodule

/* tlp_chk_pkg.sv */
// Shared types and constants of the received-packet error checker.
// Assumes a 40 MHz core clock and a link front end that has already framed each packet.
package tlp_chk_pkg;

  // Header fields of one received packet, as framed by the link front end.
  typedef struct packed {
    logic [2:0] fmt;
    logic [4:0] ftype;
    logic [2:0] tc;
    logic td;
    logic [9:0] len;
    logic [11:0] addr;
    logic [3:0] first_be;
    logic [3:0] last_be;
    logic [15:0] req_id;
    logic [7:0] tag;
    logic [2:0] cpl_status;
    logic [7:0] msg_code;
  } tlp_hdr_t;

  // Request issued by the application, remembered until its completion returns.
  typedef struct packed {
    logic [7:0] tag;
    logic is_cfg;
    logic is_io;
  } req_info_t;

  // Credits advertised for one credit class (posted, non-posted, completion).
  typedef struct packed {
    logic [7:0] hdr;
    logic [11:0] data;
  } credit_t;

  // Error status bit positions.
  localparam int ERR_W = 6;
  localparam int E_CPL_TIMEOUT = 0;
  localparam int E_CPL_ABORT = 1;
  localparam int E_UNEXP_CPL = 2;
  localparam int E_RX_OVERFLOW = 3;
  localparam int E_FC_FAULT = 4;
  localparam int E_MALFORMED = 5;
  localparam logic [5:0] FATAL_MASK = 6'h38;
  localparam logic [5:0] ERR_RESET = 6'h00;

  // Application error report bit positions.
  localparam int REP_TIMEOUT = 0;
  localparam int REP_ABORT = 2;

  // Credit classes.
  localparam int CC_POSTED = 0;
  localparam int CC_NONPOSTED = 1;
  localparam int CC_CPL = 2;

  // Field encodings.
  localparam logic [4:0] T_MEM = 5'h00;
  localparam logic [4:0] T_MEMLK = 5'h01;
  localparam logic [4:0] T_IO = 5'h02;
  localparam logic [4:0] T_CFG0 = 5'h04;
  localparam logic [4:0] T_CFG1 = 5'h05;
  localparam logic [4:0] T_CPL = 5'h0A;
  localparam logic [4:0] T_CPLLK = 5'h0B;
  localparam logic [2:0] CPL_CRS = 3'h2;
  localparam logic [2:0] TC_DEFAULT = 3'h0;
  localparam logic [10:0] MAX_IO_CPL_DW = 11'h001;
  localparam logic [11:0] PAGE_DW = 12'h400;
  localparam logic [3:0] HDR3_DW = 4'h3;
  localparam logic [3:0] HDR4_DW = 4'h4;
  localparam logic [10:0] MPS_BASE_DW = 11'h020;

  // Flow-control update watchdog.
  localparam int FC_TIMEOUT_US = 200;
  localparam int CLK_MHZ = 40;
  localparam int FC_TIMEOUT_CYC = FC_TIMEOUT_US * CLK_MHZ;

endpackage

/* tlp_error_checker.sv */
// Received-packet error checker: classifies each framed packet, drops bad ones, and keeps
// sticky error status with write-one-to-clear inputs.
// Assumes packets arrive already framed, with the count of words actually received.
`timescale 1ns/1ps

module tlp_error_checker #(
  parameter int TAGS = 32,
  parameter int FC_LIMIT = tlp_chk_pkg::FC_TIMEOUT_CYC
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Configuration.
  input wire logic [15:0] cfg_id,
  input wire logic [7:0] cfg_tag_limit,
  input wire logic [2:0] cfg_mps,
  input wire logic link_up,
  input wire logic report_en_fatal,
  input wire logic report_en_nonfatal,
  // Link receive side.
  input wire logic rx_valid,
  output logic rx_ready,
  input wire tlp_chk_pkg::tlp_hdr_t rx_hdr,
  input wire logic [11:0] rx_words,
  input wire logic rx_digest,
  input wire tlp_chk_pkg::credit_t rx_credit [3],
  input wire logic fc_update,
  // Application receive side.
  output logic app_valid,
  input wire logic app_ready,
  output tlp_chk_pkg::tlp_hdr_t app_hdr,
  // Application requests and error reports.
  input wire logic req_valid,
  input wire tlp_chk_pkg::req_info_t req_info,
  input wire logic [2:0] app_err_report,
  // Error status and signalling.
  output logic [5:0] err_status,
  input wire logic [5:0] err_clear,
  output logic err_msg_fatal,
  output logic err_msg_nonfatal
);

  // ************************************************************
  // Decode of the received header
  // ************************************************************
  tlp_chk_pkg::tlp_hdr_t h;
  logic take;
  logic has_data;
  logic is_mem;
  logic is_io;
  logic is_cfg;
  logic is_cpl;
  logic is_msg;
  logic fmt_ok;
  logic [10:0] len_dw;
  logic [11:0] exp_words;
  logic [8:0] data_cred;
  logic [1:0] cclass;
  logic [TAGS-1:0] busy;
  logic [TAGS-1:0] kind_cfg;
  logic [TAGS-1:0] kind_io;
  logic tag_in_range;
  logic unexp;
  logic overflow;
  logic malformed;
  logic drop;
  logic msg_listed;

  assign h = rx_hdr;
  assign take = rx_valid && rx_ready;
  assign has_data = h.fmt[1];
  assign len_dw = (h.len == 10'h000) ? 11'h400 : {1'b0, h.len};
  assign is_mem = (h.ftype == tlp_chk_pkg::T_MEM) || (h.ftype == tlp_chk_pkg::T_MEMLK);
  assign is_io = h.ftype == tlp_chk_pkg::T_IO;
  assign is_cfg = (h.ftype == tlp_chk_pkg::T_CFG0) || (h.ftype == tlp_chk_pkg::T_CFG1);
  assign is_cpl = (h.ftype == tlp_chk_pkg::T_CPL) || (h.ftype == tlp_chk_pkg::T_CPLLK);
  assign is_msg = h.ftype[4:3] == 2'b10;
  // Headers are 3 or 4 dwords; the digest word is counted apart from rx_words.
  assign exp_words = (h.fmt[0] ? {8'h00, tlp_chk_pkg::HDR4_DW} : {8'h00, tlp_chk_pkg::HDR3_DW})
                   + (has_data ? {1'b0, len_dw} : 12'h000);
  assign data_cred = has_data ? 9'((len_dw + 11'h003) >> 2) : 9'h000;

  // Only the defined format and type pairs are accepted.
  always_comb begin
    fmt_ok = 1'b0;
    if (h.fmt[2]) begin
      fmt_ok = 1'b0;
    end else if (is_mem) begin
      fmt_ok = (h.ftype == tlp_chk_pkg::T_MEM) || !h.fmt[1];
    end else if (is_io || is_cfg) begin
      fmt_ok = !h.fmt[0];
    end else if (is_cpl) begin
      fmt_ok = !h.fmt[0];
    end else if (is_msg) begin
      fmt_ok = h.fmt[0];
    end
  end

  // Interrupt, power, error, unlock and slot power messages.
  assign msg_listed = (h.msg_code[7:4] == 4'h2) || (h.msg_code[7:4] == 4'h3) || (h.msg_code == 8'h14)
                   || (h.msg_code == 8'h18) || (h.msg_code == 8'h19) || (h.msg_code == 8'h1B)
                   || (h.msg_code == 8'h00) || (h.msg_code == 8'h50);

  // Class of the packet for credit accounting.
  always_comb begin
    if (is_cpl) begin
      cclass = 2'(tlp_chk_pkg::CC_CPL);
    end else if (is_msg || (is_mem && has_data)) begin
      cclass = 2'(tlp_chk_pkg::CC_POSTED);
    end else begin
      cclass = 2'(tlp_chk_pkg::CC_NONPOSTED);
    end
  end

  // ************************************************************
  // Classification
  // ************************************************************
  assign tag_in_range = (h.tag < cfg_tag_limit) && (h.tag < 8'(TAGS));

  // Completion checks against the configured ID and the outstanding table.
  always_comb begin
    unexp = 1'b0;
    if (is_cpl && fmt_ok) begin
      if (h.req_id != cfg_id) begin
        unexp = 1'b1;
      end else if (!tag_in_range) begin
        unexp = 1'b1;
      end else if (!busy[h.tag[$clog2(TAGS)-1:0]]) begin
        unexp = 1'b1;
      end else if ((kind_cfg[h.tag[$clog2(TAGS)-1:0]] || kind_io[h.tag[$clog2(TAGS)-1:0]])
                   && has_data && (len_dw > tlp_chk_pkg::MAX_IO_CPL_DW)) begin
        unexp = 1'b1;
      end else if ((h.cpl_status == tlp_chk_pkg::CPL_CRS) && !kind_cfg[h.tag[$clog2(TAGS)-1:0]]) begin
        unexp = 1'b1;
      end
    end
  end

  // A packet overruns when it needs more header or data credit than was advertised.
  assign overflow = (rx_credit[cclass].hdr == 8'h00) || ({3'h0, data_cred} > rx_credit[cclass].data);

  // Malformed checks; any one of them condemns the packet.
  always_comb begin
    malformed = 1'b0;
    if (!fmt_ok) begin
      malformed = 1'b1;
    end else if (has_data && (len_dw > 11'(tlp_chk_pkg::MPS_BASE_DW << cfg_mps))) begin
      malformed = 1'b1;
    end else if (h.td != rx_digest) begin
      malformed = 1'b1;
    end else if (exp_words != rx_words) begin
      malformed = 1'b1;
    end else if ((is_mem || is_io || is_cfg) && ((len_dw == 11'h001) ? (h.last_be != 4'h0)
                 : ((h.first_be == 4'h0) || (h.last_be == 4'h0)))) begin
      malformed = 1'b1;
    end else if ((is_io || is_cfg) && (len_dw != 11'h001)) begin
      malformed = 1'b1;
    end else if (is_mem && (({2'b00, h.addr[11:2]} + {1'b0, len_dw}) > tlp_chk_pkg::PAGE_DW)) begin
      malformed = 1'b1;
    end else if (is_msg && msg_listed && (h.tc != tlp_chk_pkg::TC_DEFAULT)) begin
      malformed = 1'b1;
    end
  end

  // Malformed wins over overflow, which wins over an unexpected completion.
  assign drop = malformed || overflow || unexp;

  // ************************************************************
  // Outstanding request table
  // ************************************************************
  logic cpl_hit;
  logic [$clog2(TAGS)-1:0] hit_idx;
  assign cpl_hit = take && is_cpl && !drop;
  assign hit_idx = h.tag[$clog2(TAGS)-1:0];

  // A new request on a tag wins over a completion retiring the same tag.
  generate
    for (genvar i = 0; i < TAGS; i++) begin : g_tag
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          busy[i] <= 1'b0;
          kind_cfg[i] <= 1'b0;
          kind_io[i] <= 1'b0;
        end else if (req_valid && (req_info.tag == 8'(i))) begin
          busy[i] <= 1'b1;
          kind_cfg[i] <= req_info.is_cfg;
          kind_io[i] <= req_info.is_io;
        end else if (cpl_hit && (hit_idx == ($clog2(TAGS))'(i))) begin
          busy[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // ************************************************************
  // Two-entry delivery buffer
  // ************************************************************
  tlp_chk_pkg::tlp_hdr_t mem [2];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  logic push;
  logic pop;

  // Link is stalled only when both entries hold packets; dropped packets never enter.
  assign rx_ready = count != 2'h2;
  assign push = take && !drop;
  assign pop = app_valid && app_ready;
  assign app_valid = count != 2'h0;
  assign app_hdr = mem[rd_ptr];

  // Storage and pointers.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
      mem[0] <= '0;
      mem[1] <= '0;
    end else begin
      if (push) begin
        mem[wr_ptr] <= h;
        wr_ptr <= !wr_ptr;
      end
      if (pop) begin
        rd_ptr <= !rd_ptr;
      end
      count <= 2'(count + {1'b0, push} - {1'b0, pop});
    end
  end

  // ************************************************************
  // Flow-control update watchdog
  // ************************************************************
  logic [$clog2(FC_LIMIT+1)-1:0] fc_cnt;
  logic fc_expire;
  assign fc_expire = link_up && !fc_update && (fc_cnt == ($clog2(FC_LIMIT+1))'(FC_LIMIT - 1));

  // The count holds at the limit so that one silence raises one event.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fc_cnt <= '0;
    end else if (!link_up || fc_update) begin
      fc_cnt <= '0;
    end else if (fc_cnt != ($clog2(FC_LIMIT+1))'(FC_LIMIT)) begin
      fc_cnt <= fc_cnt + 1'b1;
    end
  end

  // ************************************************************
  // Error status and signalling
  // ************************************************************
  logic [5:0] err_set;
  assign err_set[tlp_chk_pkg::E_CPL_TIMEOUT] = app_err_report[tlp_chk_pkg::REP_TIMEOUT];
  assign err_set[tlp_chk_pkg::E_CPL_ABORT] = app_err_report[tlp_chk_pkg::REP_ABORT];
  assign err_set[tlp_chk_pkg::E_UNEXP_CPL] = take && unexp && !malformed && !overflow;
  assign err_set[tlp_chk_pkg::E_RX_OVERFLOW] = take && overflow && !malformed;
  assign err_set[tlp_chk_pkg::E_FC_FAULT] = fc_expire;
  assign err_set[tlp_chk_pkg::E_MALFORMED] = take && malformed;

  // A new event in the clearing cycle keeps its bit set.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      err_status <= tlp_chk_pkg::ERR_RESET;
    end else begin
      err_status <= (err_status & ~err_clear) | err_set;
    end
  end

  // One message pulse per cycle with an event, by severity, when enabled.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      err_msg_fatal <= 1'b0;
      err_msg_nonfatal <= 1'b0;
    end else begin
      err_msg_fatal <= report_en_fatal && |(err_set & tlp_chk_pkg::FATAL_MASK);
      err_msg_nonfatal <= report_en_nonfatal && |(err_set & ~tlp_chk_pkg::FATAL_MASK);
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_take_bad;
    take && drop;
  endsequence

  sequence s_no_pop;
    !pop;
  endsequence

  sequence s_unexp_cpl;
    take && is_cpl && fmt_ok && (h.req_id != cfg_id) && !malformed && !overflow;
  endsequence

  AST_DROP_UNEXP: assert property (s_take_bad ##0 s_no_pop |=> $stable(count))
    else $error("Dropped packet entered the delivery buffer.");
  AST_DROP_MALF: assert property (take && malformed |-> !push)
    else $error("Malformed packet was pushed.");
  AST_FOREIGN_ID: assert property (s_unexp_cpl |=> err_status[tlp_chk_pkg::E_UNEXP_CPL])
    else $error("Foreign completion not flagged.");
  AST_NO_TAG: assert property (take && is_cpl && fmt_ok && tag_in_range && (h.req_id == cfg_id)
    && !busy[hit_idx] |-> !push)
    else $error("Completion without request was delivered.");
  AST_OVERFLOW: assert property (take && overflow && !malformed |=> err_status[tlp_chk_pkg::E_RX_OVERFLOW]
    ##0 (count <= $past(count)))
    else $error("Credit overrun not flagged or not dropped.");
  AST_FC_TIMEOUT: assert property (link_up && !fc_update && (fc_cnt == ($clog2(FC_LIMIT+1))'(FC_LIMIT - 1))
    |=> err_status[tlp_chk_pkg::E_FC_FAULT])
    else $error("Credit update watchdog did not fire.");
  AST_FC_QUIET: assert property (fc_update |=> !err_set[tlp_chk_pkg::E_FC_FAULT] [*2])
    else $error("Watchdog fired right after an update.");
  AST_STICKY: assert property (err_status[tlp_chk_pkg::E_MALFORMED] && !err_clear[tlp_chk_pkg::E_MALFORMED]
    |=> err_status[tlp_chk_pkg::E_MALFORMED])
    else $error("Status bit fell without a clear.");
  AST_CLEAR: assert property (err_clear[tlp_chk_pkg::E_CPL_TIMEOUT] && !err_set[tlp_chk_pkg::E_CPL_TIMEOUT]
    |=> !err_status[tlp_chk_pkg::E_CPL_TIMEOUT])
    else $error("Write-one clear had no effect.");
  AST_REPORT: assert property (report_en_fatal && take && malformed |=> err_msg_fatal)
    else $error("Fatal error message missing.");

endmodule

/* tlp_link_partner.sv */
// Link partner model: sends credit updates and advertises credits per class.
// Assumes one core clock; the bench decides when it falls silent or starves posted credits.
`timescale 1ns/1ps
module tlp_link_partner #(
  parameter int GAP = 8
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Bench controls.
  input wire logic silent,
  input wire logic starve,
  // Link side.
  output logic fc_update,
  output tlp_chk_pkg::credit_t rx_credit [3]
);
  int gap;

  // An update every GAP cycles; a silent partner sends none, as a stalled link would.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gap <= 0;
      fc_update <= 1'b0;
    end else begin
      gap <= (gap == GAP - 1) ? 0 : gap + 1;
      fc_update <= !silent && (gap == GAP - 1);
    end
  end

  // Starving zeroes posted header credits so that any posted packet overruns.
  assign rx_credit[0] = '{hdr: starve ? 8'h00 : 8'hFF, data: 12'hFFF};
  assign rx_credit[1] = '{hdr: 8'hFF, data: 12'hFFF};
  assign rx_credit[2] = '{hdr: 8'hFF, data: 12'hFFF};
endmodule
